//--- verilog/acxc_unit.sv
module acxc_unit (
  input logic hclk,
  input logic hresetn,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input acxc_pkg::acxc_req_s req,
  output logic req_ready,
  output logic done,
  output logic wm_rd,
  output logic [acxc_pkg::AW-1:0] wm_addr,
  input logic [acxc_pkg::WW-1:0] wm_rdata,
  output logic bm_rd,
  output logic [acxc_pkg::AW-1:0] bm_addr,
  input logic [acxc_pkg::DW-1:0] bm_rdata,
  output acxc_pkg::acxc_flags_s flags,
  output logic irq
);

  // ----------------------------------------
  // functions
  // ----------------------------------------

  // low-bit mask for a field of count bits
  function automatic logic [31:0] fmask(input logic [5:0] cnt);
    logic [31:0] m;
    m = (32'h1 << cnt) - 32'h1;
    // count of 32 means full word
    if (cnt >= acxc_pkg::CNT_FULL) begin
      m = 32'hffffffff;
    end
    return m;
  endfunction

  // unsigned relation: {less, equal, greater}
  function automatic logic [2:0] rel3(input logic [31:0] a, input logic [31:0] b);
    return {a < b, a == b, a > b};
  endfunction

  // ----------------------------------------
  // state declarations
  // ----------------------------------------
  acxc_pkg::acxc_state_e state_r, state_nxt; // sequencing state
  acxc_pkg::acxc_req_s cmd_r; // accepted command
  logic [31:0] acc_r; // accumulator
  logic [31:0] opnd_r; // fetched operand
  logic [31:0] stack_r [acxc_pkg::SD]; // accumulator stack
  logic [acxc_pkg::DEPW-1:0] depth_r; // stack fill level
  acxc_pkg::acxc_flags_s flags_r; // status flags
  logic ctrl_en_r; // software enable
  logic [acxc_pkg::STW-1:0] status_r; // sticky events
  logic [acxc_pkg::STW-1:0] mask_r; // event mask
  logic irq_r; // interrupt line
  logic req_ready_r; // request acceptance
  logic done_r; // completion pulse
  logic wm_rd_r, bm_rd_r; // memory read strobes
  logic [acxc_pkg::AW-1:0] wm_addr_r, bm_addr_r; // memory addresses
  logic [31:0] hrdata_r; // bus read data
  logic hreadyout_r, hresp_r; // bus answer
  logic wr_pend_r; // write data phase pending
  logic [acxc_pkg::OFW-1:0] wr_addr_r; // write target

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire addr_ph = hsel & htrans[1] & hready; // valid address phase
  wire rd_now = addr_ph & ~hwrite; // read taken this edge
  wire [acxc_pkg::OFW-1:0] a_off = haddr[acxc_pkg::OFW-1:0];
  wire stat_clr = rd_now & (a_off == acxc_pkg::A_STAT); // read clears status
  wire wr_ctrl = wr_pend_r & (wr_addr_r == acxc_pkg::A_CTRL);
  wire wr_mask = wr_pend_r & (wr_addr_r == acxc_pkg::A_MASK);

  // read data selection; unmapped reads zero
  wire [31:0] rd_val =
    (a_off == acxc_pkg::A_CTRL) ? {31'h0, ctrl_en_r} :
    (a_off == acxc_pkg::A_ACC) ? acc_r :
    (a_off == acxc_pkg::A_FLAGS) ? {27'h0, flags_r} :
    (a_off == acxc_pkg::A_DEPTH) ? {28'h0, depth_r} :
    (a_off == acxc_pkg::A_STAT) ? {29'h0, status_r} :
    (a_off == acxc_pkg::A_MASK) ? {29'h0, mask_r} : 32'h0;

  // ----------------------------------------
  // datapath decode
  // ----------------------------------------
  wire idle = state_r == acxc_pkg::ACXC_IDLE;
  wire take = idle & req.valid & req_ready_r; // command accepted
  wire exec = state_r == acxc_pkg::ACXC_EXEC;
  wire is_cmp = (cmd_r.op == acxc_pkg::ACXC_CMP) | (cmd_r.op == acxc_pkg::ACXC_DOUBLE_COMPARE_OP) |
                (cmd_r.op == acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP);
  wire do_xor = exec & (cmd_r.op == acxc_pkg::ACXC_XOR);
  wire do_load = exec & (cmd_r.op == acxc_pkg::ACXC_LOAD);
  wire do_cmp = exec & is_cmp;
  wire stk_empty = depth_r == '0;
  wire [31:0] top = stk_empty ? 32'h0 : stack_r[0]; // empty stack reads zero
  wire [31:0] xor_res = acc_r ^ top;
  // low half against the memory word
  wire [31:0] cmp_a = (cmd_r.op == acxc_pkg::ACXC_CMP) ? {16'h0, acc_r[15:0]} : acc_r;
  wire [31:0] cmp_b =
    (cmd_r.op == acxc_pkg::ACXC_DOUBLE_COMPARE_OP && cmd_r.use_const) ? cmd_r.konst :
    // only the counted memory bits take part; the accumulator is compared in full
    (cmd_r.op == acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP) ? (opnd_r & fmask(cmd_r.count)) : opnd_r;
  // unsigned order suits bcd, hex and binary
  wire [2:0] rel = rel3(cmp_a, cmp_b);
  wire need_wm = (req.op == acxc_pkg::ACXC_CMP) |
                 (req.op == acxc_pkg::ACXC_DOUBLE_COMPARE_OP && !req.use_const);
  wire need_bm = req.op == acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP;
  wire two_words = cmd_r.op == acxc_pkg::ACXC_DOUBLE_COMPARE_OP;
  wire [acxc_pkg::STW-1:0] ev_set = {do_xor & stk_empty, do_cmp, do_xor};
  wire [acxc_pkg::STW-1:0] status_nxt = (status_r & ~({acxc_pkg::STW{stat_clr}})) | ev_set;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      acxc_pkg::ACXC_IDLE: begin
        // memory operands are fetched first
        if (take) begin
          state_nxt = (need_wm | need_bm) ? acxc_pkg::ACXC_RD : acxc_pkg::ACXC_EXEC;
        end
      end
      acxc_pkg::ACXC_RD: state_nxt = acxc_pkg::ACXC_LO;
      // second word only for double compare
      acxc_pkg::ACXC_LO: state_nxt = two_words ? acxc_pkg::ACXC_HI : acxc_pkg::ACXC_EXEC;
      acxc_pkg::ACXC_HI: state_nxt = acxc_pkg::ACXC_EXEC;
      acxc_pkg::ACXC_EXEC: state_nxt = acxc_pkg::ACXC_IDLE;
      default: state_nxt = acxc_pkg::ACXC_IDLE;
    endcase
  end

  // state and handshake registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= acxc_pkg::ACXC_IDLE;
      req_ready_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_ready_r <= (state_nxt == acxc_pkg::ACXC_IDLE) & ctrl_en_r & ~take;
      done_r <= exec;
    end
  end

  // command latch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmd_r <= '0;
    end else if (take) begin
      cmd_r <= req;
    end
  end

  // ----------------------------------------
  // operand fetch
  // ----------------------------------------

  // word memory strobe: low word then high word
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wm_rd_r <= 1'b0;
      wm_addr_r <= '0;
    end else if (take & need_wm) begin
      wm_rd_r <= 1'b1;
      wm_addr_r <= req.addr;
    end else if (state_r == acxc_pkg::ACXC_RD && two_words) begin
      // next consecutive word is the high half
      wm_addr_r <= wm_addr_r + 16'h1;
    end else begin
      wm_rd_r <= 1'b0;
    end
  end

  // discrete bit memory strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bm_rd_r <= 1'b0;
      bm_addr_r <= '0;
    end else begin
      bm_rd_r <= take & need_bm;
      if (take & need_bm) begin
        bm_addr_r <= req.addr;
      end
    end
  end

  // operand capture one cycle after each strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      opnd_r <= '0;
    end else if (state_r == acxc_pkg::ACXC_LO) begin
      opnd_r <= (cmd_r.op == acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP) ? bm_rdata : {16'h0, wm_rdata};
    end else if (state_r == acxc_pkg::ACXC_HI) begin
      opnd_r <= {wm_rdata, opnd_r[15:0]};
    end
  end

  // ----------------------------------------
  // accumulator and stack
  // ----------------------------------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= '0;
    end else if (do_load) begin
      acc_r <= cmd_r.konst;
    end else if (do_xor) begin
      acc_r <= xor_res;
    end
  end

  // stack levels shift down on load, up on xor
  for (genvar i = 0; i < acxc_pkg::SD; i++) begin : g_stk
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stack_r[i] <= '0;
      end else if (do_load) begin
        stack_r[i] <= (i == 0) ? acc_r : stack_r[(i == 0) ? 0 : i - 1];
      end else if (do_xor) begin
        // first level dropped, rest move up
        stack_r[i] <= (i == acxc_pkg::SD - 1) ? 32'h0 : stack_r[(i == acxc_pkg::SD - 1) ? i : i + 1];
      end
    end
  end

  // stack depth; untouched by compares
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      depth_r <= '0;
    end else if (do_load && depth_r != acxc_pkg::DEP_MAX) begin
      depth_r <= depth_r + 4'h1;
    end else if (do_xor && !stk_empty) begin
      depth_r <= depth_r - 4'h1;
    end
  end

  // ----------------------------------------
  // status flags
  // ----------------------------------------

  // each flag group written only by its op
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flags_r <= '0;
    end else begin
      if (do_xor) begin
        // zero and sign of the result
        flags_r.zero_result_flag <= xor_res == 32'h0;
        flags_r.negative_result_flag <= xor_res[31];
      end
      if (do_cmp) begin
        flags_r.less_than_flag <= rel[2];
        flags_r.equal_flag <= rel[1];
        flags_r.greater_than_flag <= rel[0];
      end
    end
  end

  // ----------------------------------------
  // bus slave and interrupt
  // ----------------------------------------

  // read data captured at the address edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      hrdata_r <= rd_now ? rd_val : 32'h0;
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
      wr_pend_r <= addr_ph & hwrite;
      wr_addr_r <= a_off;
    end
  end

  // writable registers, data phase of a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_en_r <= acxc_pkg::CTRL_RST;
      mask_r <= acxc_pkg::MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_en_r <= hwdata[acxc_pkg::CTRL_EN];
      end
      if (wr_mask) begin
        mask_r <= hwdata[acxc_pkg::STW-1:0];
      end
    end
  end

  // sticky events, set wins over read clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign req_ready = req_ready_r;
  assign done = done_r;
  assign wm_rd = wm_rd_r;
  assign wm_addr = wm_addr_r;
  assign bm_rd = bm_rd_r;
  assign bm_addr = bm_addr_r;
  assign flags = flags_r;
  assign irq = irq_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  xor_value_a: assert property (do_xor |=> acc_r == ($past(acc_r) ^ $past(top)))
    else $error("xor result wrong");
  stack_pop_a: assert property (do_xor && depth_r > 1 |=>
    stack_r[0] == $past(stack_r[1]) && depth_r == $past(depth_r) - 1)
    else $error("stack not popped");
  xor_flags_a: assert property (do_xor |=>
    flags_r.zero_result_flag == (acc_r == 0) && flags_r.negative_result_flag == acc_r[31])
    else $error("xor flags wrong");
  zn_hold_a: assert property (!do_xor |=>
    $stable(flags_r.zero_result_flag) && $stable(flags_r.negative_result_flag))
    else $error("zero or sign flag moved");
  rel_hold_a: assert property (!do_cmp |=> $stable(flags_r.less_than_flag) &&
    $stable(flags_r.equal_flag) && $stable(flags_r.greater_than_flag))
    else $error("relation flag moved");
  word_cmp_a: assert property (exec && cmd_r.op == acxc_pkg::ACXC_CMP |=>
    flags_r.less_than_flag == ($past(acc_r[15:0]) < $past(opnd_r[15:0])))
    else $error("word compare wrong");
  rel_order_a: assert property (do_cmp |=> flags_r.equal_flag == ($past(cmp_a) == $past(cmp_b)) &&
    flags_r.greater_than_flag == ($past(cmp_a) > $past(cmp_b)))
    else $error("relation wrong");
  cmp_keep_a: assert property (do_cmp |=>
    $stable(acc_r) && $stable(depth_r) && $stable(stack_r[0]))
    else $error("compare changed data");
  dword_const_a: assert property (exec && two_words && cmd_r.use_const |=>
    flags_r.greater_than_flag == ($past(acc_r) > $past(cmd_r.konst)))
    else $error("double compare wrong");
  field_cmp_a: assert property (exec && cmd_r.op == acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP |=>
    flags_r.equal_flag == ($past(acc_r) == ($past(opnd_r) & fmask($past(cmd_r.count)))))
    else $error("field compare wrong");
  one_rel_a: assert property (do_cmp |=> $onehot({flags_r.less_than_flag,
    flags_r.equal_flag, flags_r.greater_than_flag}))
    else $error("relation flags not one-hot");
  fetch_time_a: assert property (take && need_wm && req.op == acxc_pkg::ACXC_DOUBLE_COMPARE_OP |=>
    wm_rd_r ##1 wm_rd_r ##1 !wm_rd_r ##1 exec)
    else $error("double fetch timing wrong");

  xor_seen_c: cover property (do_xor ##1 flags_r.zero_result_flag);
  dword_seen_c: cover property (exec && two_words && !cmd_r.use_const);
  field_seen_c: cover property (exec && cmd_r.op == acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP ##1 flags_r.less_than_flag);
  irq_seen_c: cover property (status_r[acxc_pkg::ST_UFL] && irq_r);

endmodule

//--- verilog/acxc_pkg.sv
// Contract
// - stack xor replaces full 32-bit accumulator
// - stack xor pops level one, entries move up
// - xor sets zero and negative result flags
// - flags hold until an op rewrites them
// - word compare uses accumulator low 16 bits
// - compare sets less, equal or greater
// - compares never change the accumulator
// - double compare: two words or constant
// - field compare against 1-32 discrete bits
// - ordering correct for bcd, decimal, binary
package acxc_pkg;

  // ----------------------------------------
  // widths and sizes
  // ----------------------------------------
  localparam int unsigned DW = 32;
  localparam int unsigned WW = 16;
  localparam int unsigned AW = 16;
  localparam int unsigned SD = 8;
  localparam int unsigned DEPW = 4;
  localparam int unsigned CNTW = 6;
  localparam int unsigned OFW = 8;

  // ----------------------------------------
  // register offsets and fields
  // ----------------------------------------
  localparam logic [OFW-1:0] A_CTRL = 8'h00;
  localparam logic [OFW-1:0] A_ACC = 8'h04;
  localparam logic [OFW-1:0] A_FLAGS = 8'h08;
  localparam logic [OFW-1:0] A_DEPTH = 8'h0c;
  localparam logic [OFW-1:0] A_STAT = 8'h10;
  localparam logic [OFW-1:0] A_MASK = 8'h14;
  localparam int unsigned CTRL_EN = 0;
  localparam logic CTRL_RST = 1'b1;
  localparam int unsigned STW = 3;
  localparam int unsigned ST_XOR = 0;
  localparam int unsigned ST_CMP = 1;
  localparam int unsigned ST_UFL = 2;
  localparam logic [STW-1:0] MASK_RST = 3'h0;
  localparam logic [DEPW-1:0] DEP_MAX = 4'h8;
  localparam logic [CNTW-1:0] CNT_FULL = 6'h20;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    ACXC_NOP, ACXC_LOAD, ACXC_XOR, ACXC_CMP, ACXC_DOUBLE_COMPARE_OP, ACXC_BIT_FIELD_COMPARE_OP
  } acxc_op_e;

  typedef enum logic [2:0] {
    ACXC_IDLE, ACXC_RD, ACXC_LO, ACXC_HI, ACXC_EXEC
  } acxc_state_e;

  typedef struct packed {
    logic valid;
    acxc_op_e op;
    logic use_const;
    logic [AW-1:0] addr;
    logic [DW-1:0] konst;
    logic [CNTW-1:0] count;
  } acxc_req_s;

  typedef struct packed {
    logic zero_result_flag;
    logic negative_result_flag;
    logic less_than_flag;
    logic equal_flag;
    logic greater_than_flag;
  } acxc_flags_s;

endpackage

//--- bench/acxc_mem_model.sv
// ----------------------------------------
// operand memories seen by the unit
// ----------------------------------------
module acxc_mem_model (
  input wire logic hclk,
  input wire logic wm_rd,
  input wire logic [acxc_pkg::AW-1:0] wm_addr,
  output logic [acxc_pkg::WW-1:0] wm_rdata,
  input wire logic bm_rd,
  input wire logic [acxc_pkg::AW-1:0] bm_addr,
  output logic [acxc_pkg::DW-1:0] bm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] wmem [0:63]; // word memory image
  logic [31:0] bmem [0:15]; // discrete bits, bit0 at the start location
  initial begin
    wm_rdata = 16'h0;
    bm_rdata = 32'h0;
  end
  // data stands one cycle after a strobe, then turns to its inverse
  always @(posedge hclk) begin
    if (wm_rd) begin
      wm_rdata <= wmem[wm_addr[5:0]];
    end else begin
      wm_rdata <= ~wm_rdata;
    end
    if (bm_rd) begin
      bm_rdata <= bmem[bm_addr[3:0]];
    end else begin
      bm_rdata <= ~bm_rdata;
    end
  end
endmodule

//--- bench/acxc_unit_tb.sv
module acxc_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic hready; // the one slave drives the bus ready
  wire logic hresp; // slave response, always okay
  logic [31:0] hrdata;
  acxc_pkg::acxc_req_s req = '0;
  logic req_ready, done, wm_rd, bm_rd, irq;
  logic [15:0] wm_addr, wm_rdata, bm_addr;
  logic [31:0] bm_rdata;
  acxc_pkg::acxc_flags_s flags;
  int failures = 0;
  int total_checks = 0;
  localparam logic [31:0] P = 32'hf0f00f0f; // first loaded value
  localparam logic [31:0] Q = 32'h0ff0f00f; // second loaded value
  always #2 hclk = ~hclk;
  acxc_unit acxc_unit_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
    .hresp(hresp), .req(req), .req_ready(req_ready), .done(done), .wm_rd(wm_rd), .wm_addr(wm_addr),
    .wm_rdata(wm_rdata), .bm_rd(bm_rd), .bm_addr(bm_addr), .bm_rdata(bm_rdata), .flags(flags), .irq(irq));
  acxc_mem_model acxc_mem_model_inst (.hclk(hclk), .wm_rd(wm_rd), .wm_addr(wm_addr), .wm_rdata(wm_rdata),
    .bm_rd(bm_rd), .bm_addr(bm_addr), .bm_rdata(bm_rdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single-word transfer, waiting on ready in both phases
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 100);
    rd = hrdata;
    // a wait that ran out, or an error response, counts as a mismatch
    check({30'h0, hready, hresp}, 32'h2);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    check(x, exp);
  endtask
  // hand one request to the unit and wait for its done pulse
  task automatic run_op(input acxc_pkg::acxc_op_e op, input logic uc, input logic [15:0] a,
                        input logic [31:0] k, input logic [5:0] c);
    int n;
    n = 0;
    @(posedge hclk);
    req <= '{valid: 1'b1, op: op, use_const: uc, addr: a, konst: k, count: c};
    do @(posedge hclk); while (req_ready !== 1'b1 && ++n < 50);
    req.valid <= 1'b0;
    do @(posedge hclk); while (done !== 1'b1 && ++n < 100);
    // a request that never finished counts as a mismatch
    check({31'h0, done}, 32'h1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rdchk(acxc_pkg::A_CTRL, 32'h1);
    rdchk(acxc_pkg::A_MASK, 32'h0);
    rdchk(acxc_pkg::A_DEPTH, 32'h0);
    rdchk(acxc_pkg::A_FLAGS, 32'h0);
    wr(acxc_pkg::A_ACC, 32'h5a5a5a5a); // read-only place ignores writes
    rdchk(acxc_pkg::A_ACC, 32'h0);
    rdchk(8'h3c, 32'h0); // unmapped
    $display("test regs done");
  endtask
  task automatic t_xor();
    run_op(acxc_pkg::ACXC_LOAD, 1'b1, 16'h0, P, 6'h0);
    run_op(acxc_pkg::ACXC_LOAD, 1'b1, 16'h0, Q, 6'h0);
    run_op(acxc_pkg::ACXC_LOAD, 1'b1, 16'h0, Q, 6'h0);
    rdchk(acxc_pkg::A_STAT, 32'h0);
    run_op(acxc_pkg::ACXC_XOR, 1'b0, 16'h0, 32'h0, 6'h0);
    check({27'h0, flags}, 32'h10);
    rdchk(acxc_pkg::A_ACC, 32'h0);
    rdchk(acxc_pkg::A_DEPTH, 32'h2);
    run_op(acxc_pkg::ACXC_XOR, 1'b0, 16'h0, 32'h0, 6'h0);
    rdchk(acxc_pkg::A_ACC, P);
    check({27'h0, flags}, 32'h08);
    run_op(acxc_pkg::ACXC_XOR, 1'b0, 16'h0, 32'h0, 6'h0);
    run_op(acxc_pkg::ACXC_XOR, 1'b0, 16'h0, 32'h0, 6'h0);
    rdchk(acxc_pkg::A_ACC, P);
    rdchk(acxc_pkg::A_DEPTH, 32'h0);
    rdchk(acxc_pkg::A_STAT, 32'h5);
    rdchk(acxc_pkg::A_STAT, 32'h0);
    $display("test xor done");
  endtask
  task automatic t_cmp();
    acxc_pkg::acxc_op_e ops [10] = '{acxc_pkg::ACXC_CMP, acxc_pkg::ACXC_CMP, acxc_pkg::ACXC_CMP,
      acxc_pkg::ACXC_DOUBLE_COMPARE_OP, acxc_pkg::ACXC_DOUBLE_COMPARE_OP, acxc_pkg::ACXC_DOUBLE_COMPARE_OP, acxc_pkg::ACXC_DOUBLE_COMPARE_OP,
      acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP, acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP, acxc_pkg::ACXC_BIT_FIELD_COMPARE_OP};
    logic ucs [10] = '{0, 0, 0, 0, 0, 1, 1, 0, 0, 0};
    logic [15:0] ads [10] = '{1, 2, 3, 8, 10, 0, 0, 3, 5, 6};
    logic [31:0] ks [10] = '{0, 0, 0, 0, 0, 32'hf0f00f10, P, 0, 0, 0};
    logic [5:0] cs [10] = '{0, 0, 0, 0, 0, 0, 0, 6'h20, 6'h4, 6'h1};
    logic [2:0] rel [10] = '{3'h2, 3'h4, 3'h1, 3'h2, 3'h1, 3'h4, 3'h2, 3'h4, 3'h1, 3'h1};
    acxc_mem_model_inst.wmem[1] = 16'h0f0f;
    acxc_mem_model_inst.wmem[2] = 16'h0f10;
    acxc_mem_model_inst.wmem[3] = 16'h0f0e;
    acxc_mem_model_inst.wmem[8] = 16'h0f0f;
    acxc_mem_model_inst.wmem[9] = 16'hf0f0;
    acxc_mem_model_inst.wmem[10] = 16'h0f0e;
    acxc_mem_model_inst.wmem[11] = 16'hf0f0;
    acxc_mem_model_inst.bmem[3] = 32'hf0f00f10;
    acxc_mem_model_inst.bmem[5] = 32'hffffffff;
    acxc_mem_model_inst.bmem[6] = 32'hfffffffe;
    wr(acxc_pkg::A_MASK, 32'h2);
    for (int i = 0; i < 10; i++) begin
      // field compare bit counts handed over stay within 1 to 32
      // sequencer count
      run_op(ops[i], ucs[i], ads[i], ks[i], cs[i]);
      check({27'h0, flags}, {27'h0, 2'b01, rel[i]});
    end
    rdchk(acxc_pkg::A_ACC, P);
    rdchk(acxc_pkg::A_DEPTH, 32'h0);
    check({31'h0, irq}, 32'h1);
    rdchk(acxc_pkg::A_STAT, 32'h2);
    repeat (3) @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    $display("test compare done");
  endtask
  task automatic t_enable();
    wr(acxc_pkg::A_CTRL, 32'h0);
    repeat (2) @(posedge hclk);
    check({31'h0, req_ready}, 32'h0);
    wr(acxc_pkg::A_CTRL, 32'h1);
    repeat (2) @(posedge hclk);
    check({31'h0, req_ready}, 32'h1);
    $display("test enable done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    t_xor();
    t_cmp();
    t_enable();
    give_verdict();
  end
  initial begin
    #40000;
    failures++;
    give_verdict();
  end
endmodule
